//--- core/srm_top.sv
module srm_top
  import srm_pkg::*;
#(
  parameter int unsigned DIV = SLOW_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  input wire logic core_rst_b,
  input wire logic backup_exit,
  input wire logic wdt_fault,
  input wire logic watchdog_reset_enable,
  input wire logic watchdog_processor_only,
  output logic proc_rst_b,
  output logic coproc_rst_b,
  output logic periph_rst_b,
  output logic coproc_periph_rst_b,
  output logic wdt_rst_b,
  output logic user_irq
);

  typedef struct packed {
    logic [15:0] div;
    logic tick;
    logic [2:0] pin_s;
    logic pin_lvl;
    logic [2:0] core_s;
    logic core_lvl;
    logic [2:0] bk_s;
    logic bk_lvl;
    logic bk_seen;
    logic [2:0] low_cnt;
    logic ign;
    logic seen;
    logic irq;
    srm_state_t st;
    logic [1:0] cnt;
    logic wdt_pend;
    logic wdt_full;
    logic [16:0] ext_cnt;
    logic [2:0] cause;
    logic user_reset_enable;
    logic user_reset_irq_enable;
    logic [3:0] pin_assert_length;
    logic proc;
    logic coproc;
    logic periph;
    logic cperiph;
    logic oe;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } srm_reg_t;

  srm_reg_t r;
  srm_reg_t n;
  logic pin_evt;
  logic rd_sr;
  logic acc;
  logic [16:0] ext_len;

  always_comb begin
    n = r;
    pin_evt = 1'b0;
    acc = psel && penable && r.rdy;
    rd_sr = acc && !pwrite && (paddr == ADDR_STATUS);
    ext_len = 17'h00001 << ({1'b0, r.pin_assert_length} + 5'h01);
    n.tick = 1'b0;
    n.irq = 1'b0;
    if (r.div == 16'(DIV - 1)) begin
      n.div = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.div = r.div + 16'h0001;
    end

    // Three-stage synchronisers; a level counts once stages two and three
    // agree, which rejects a single metastable sample.
    n.pin_s = {r.pin_s[1:0], pin_in};
    n.core_s = {r.core_s[1:0], core_rst_b};
    n.bk_s = {r.bk_s[1:0], backup_exit};
    if (r.pin_s[1] == r.pin_s[2]) begin
      n.pin_lvl = r.pin_s[2];
    end
    if (r.core_s[1] == r.core_s[2]) begin
      n.core_lvl = r.core_s[2];
    end
    if (r.bk_s[1] == r.bk_s[2]) begin
      n.bk_lvl = r.bk_s[2];
    end

    // Only bits that were returned by the read are cleared, so an assertion
    // landing between setup and access is kept; a new set wins the clear.
    if (rd_sr && r.rdata[SR_SEEN_BIT]) begin
      n.seen = 1'b0;
    end
    if (!r.pin_lvl) begin
      n.seen = 1'b1;
    end

    // A fault with resets disabled leaves no trace at all.
    if (wdt_fault && watchdog_reset_enable) begin
      n.wdt_pend = 1'b1;
    end

    // APB slave: no wait states, registered answer.
    n.rdy = 1'b0;
    n.err = 1'b0;
    if (psel && !penable) begin
      n.rdy = 1'b1;
      n.rdata = 32'h00000000;
      case (paddr)
        ADDR_STATUS: begin
          n.rdata[SR_SEEN_BIT] = r.seen;
          n.rdata[SR_CAUSE_LSB +: 3] = r.cause;
          n.rdata[SR_LEVEL_BIT] = r.pin_lvl;
        end
        ADDR_MODE: begin
          n.rdata[MR_URE_BIT] = r.user_reset_enable;
          n.rdata[MR_IRQE_BIT] = r.user_reset_irq_enable;
          n.rdata[MR_LEN_LSB +: 4] = r.pin_assert_length;
        end
        ADDR_CTRL, ADDR_CPMODE: begin
          n.rdata = 32'h00000000;
        end
        default: begin
          n.err = 1'b1;
        end
      endcase
    end
    // The mode register is only cleared by rst_b, the backup-domain reset,
    // never by the core supply or any reset this block produces.
    if (acc && pwrite && (paddr == ADDR_MODE)) begin
      n.user_reset_enable = pwdata[MR_URE_BIT];
      n.user_reset_irq_enable = pwdata[MR_IRQE_BIT];
      n.pin_assert_length = pwdata[MR_LEN_LSB +: 4];
    end

    if (r.tick) begin
      // Pin sampler; lows caused by our own drive are ignored until the
      // pin is seen high again. The ignore flag must be up before the
      // synchronised low reaches a tick, so DIV may not be above four.
      n.ign = r.oe || (r.ign && !r.pin_lvl);
      if (r.pin_lvl || r.ign) begin
        n.low_cnt = 3'h0;
      end else if (r.low_cnt != PIN_LOW_TICKS) begin
        n.low_cnt = r.low_cnt + 3'h1;
        pin_evt = (r.low_cnt == PIN_LOW_TICKS - 3'h1);
      end

      if (r.ext_cnt != 17'h00000) begin
        n.ext_cnt = r.ext_cnt - 17'h00001;
      end

      case (r.st)
        SRM_GEN: begin
          if (r.bk_lvl) begin
            n.bk_seen = 1'b1;
          end
          if (r.core_lvl) begin
            n.proc = 1'b1;
            n.coproc = 1'b1;
            n.periph = 1'b1;
            n.cperiph = 1'b1;
            n.cause = r.bk_seen ? CAUSE_BACKUP : CAUSE_GENERAL;
            n.ext_cnt = ext_len;
            n.bk_seen = 1'b0;
            n.wdt_pend = 1'b0;
            n.st = SRM_RUN;
          end
        end
        SRM_RUN: begin
          if (r.wdt_pend) begin
            n.wdt_pend = 1'b0;
            n.wdt_full = !watchdog_processor_only;
            n.proc = 1'b0;
            n.cnt = 2'h0;
            if (!watchdog_processor_only) begin
              n.periph = 1'b0;
              n.ext_cnt = ext_len;
            end
            n.st = SRM_WDT;
          end else if (pin_evt && r.user_reset_irq_enable) begin
            n.irq = 1'b1;
          end else if (pin_evt && r.user_reset_enable) begin
            n.proc = 1'b0;
            n.coproc = 1'b0;
            n.periph = 1'b0;
            n.cperiph = 1'b0;
            n.cnt = 2'h0;
            n.st = SRM_USER;
          end
        end
        SRM_WDT: begin
          // A fault arriving here stays pending and restarts the watchdog
          // reset once the processor runs again.
          n.cnt = r.cnt + 2'h1;
          if (r.cnt == WDT_TICKS - 2'h1) begin
            n.proc = 1'b1;
            if (r.wdt_full) begin
              n.periph = 1'b1;
            end
            n.cause = CAUSE_WATCHDOG;
            n.st = SRM_RUN;
          end
        end
        SRM_USER: begin
          // A watchdog fault arriving while the processor is held here is dropped.
          n.wdt_pend = 1'b0;
          if (!r.pin_lvl) begin
            n.cnt = 2'h0;
          end else if (r.cnt == STARTUP_TICKS - 2'h1) begin
            n.proc = 1'b1;
            n.coproc = 1'b1;
            n.periph = 1'b1;
            n.cperiph = 1'b1;
            n.cause = CAUSE_USER;
            n.st = SRM_RUN;
          end else begin
            n.cnt = r.cnt + 2'h1;
          end
        end
        default: begin
          n.st = SRM_GEN;
        end
      endcase

      // Supply reset outranks every other source.
      if (!r.core_lvl) begin
        n.proc = 1'b0;
        n.coproc = 1'b0;
        n.periph = 1'b0;
        n.cperiph = 1'b0;
        n.ext_cnt = 17'h00000;
        n.st = SRM_GEN;
        if (r.bk_lvl) begin
          n.bk_seen = 1'b1;
        end
      end
      n.oe = (n.ext_cnt != 17'h00000);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.pin_s <= 3'h7;
      r.pin_lvl <= 1'b1;
      r.st <= SRM_GEN;
      r.user_reset_enable <= MR_URE_RST;
      r.user_reset_irq_enable <= MR_IRQE_RST;
      r.pin_assert_length <= MR_LEN_RST;
      r.cause <= CAUSE_GENERAL;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  // Open drain: only the enable moves, the driven level is always low.
  assign pin_out = 1'b0;
  assign pin_oe = r.oe;
  assign proc_rst_b = r.proc;
  assign coproc_rst_b = r.coproc;
  assign periph_rst_b = r.periph;
  assign coproc_periph_rst_b = r.cperiph;
  assign wdt_rst_b = r.proc;
  assign user_irq = r.irq;

endmodule : srm_top

//--- core/srm_pkg.sv
package srm_pkg;
  // Clock and slow-clock rate.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SLOW_HZ = 32768;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_CPMODE = 8'h0C;
  // Status register fields.
  localparam int unsigned SR_SEEN_BIT = 0;
  localparam int unsigned SR_CAUSE_LSB = 8;
  localparam int unsigned SR_LEVEL_BIT = 16;
  // Mode register fields and reset values.
  localparam int unsigned MR_URE_BIT = 0;
  localparam int unsigned MR_IRQE_BIT = 4;
  localparam int unsigned MR_LEN_LSB = 8;
  localparam logic MR_URE_RST = 1'b1;
  localparam logic MR_IRQE_RST = 1'b0;
  localparam logic [3:0] MR_LEN_RST = 4'h0;
  // Last reset cause codes.
  localparam logic [2:0] CAUSE_GENERAL = 3'h0;
  localparam logic [2:0] CAUSE_BACKUP = 3'h1;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_USER = 3'h4;
  // Slow-clock counts.
  localparam logic [2:0] PIN_LOW_TICKS = 3'h4;
  localparam logic [1:0] WDT_TICKS = 2'h3;
  localparam logic [1:0] STARTUP_TICKS = 2'h3;
  typedef enum logic [1:0] {
    SRM_GEN,
    SRM_RUN,
    SRM_WDT,
    SRM_USER
  } srm_state_t;
endpackage : srm_pkg

//--- tb/srm_asserts.sv
module srm_asserts
  import srm_pkg::*;
#(
  parameter int unsigned DIV = SLOW_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdt_fault,
  input wire logic watchdog_reset_enable,
  input wire logic proc_rst_b,
  input wire logic coproc_rst_b,
  input wire logic periph_rst_b,
  input wire logic wdt_rst_b,
  input wire logic user_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  int unsigned low_r;
  // A counter measures the hold, since a long repetition would be unrolled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) low_r <= '0;
    else if (proc_rst_b) low_r <= '0;
    else low_r <= low_r + 1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wdt_end;
    $rose(proc_rst_b) && $past(coproc_rst_b);
  endsequence
  a_setup_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_err_map: assert property (pready |->
    pslverr == (paddr > ADDR_CPMODE || paddr[1:0] != 2'h0))
    else $error("wrong error response");
  a_wdt_follows: assert property ($changed(proc_rst_b) |->
    ##[0:1] (wdt_rst_b == proc_rst_b)) else $error("watchdog reset lags");
  a_wdt_three: assert property (s_wdt_end |-> low_r == 3 * DIV)
    else $error("watchdog reset length wrong");
  a_coproc_all: assert property (!coproc_rst_b |->
    !proc_rst_b && !periph_rst_b) else $error("coprocessor reset alone");
  a_periph_proc: assert property (!periph_rst_b |-> !proc_rst_b)
    else $error("peripheral reset without processor reset");
  a_wdt_off: assert property (
    wdt_fault && !watchdog_reset_enable && proc_rst_b |=> proc_rst_b [*8])
    else $error("disabled fault reset");
  a_irq_pulse: assert property (user_irq |->
    proc_rst_b ##1 !user_irq) else $error("bad interrupt pulse");
endmodule : srm_asserts
bind srm_top srm_asserts #(.DIV(DIV)) u_srm_asserts (
  .clk(clk),
  .rst_b(rst_b),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .wdt_fault(wdt_fault),
  .watchdog_reset_enable(watchdog_reset_enable),
  .proc_rst_b(proc_rst_b),
  .coproc_rst_b(coproc_rst_b),
  .periph_rst_b(periph_rst_b),
  .wdt_rst_b(wdt_rst_b),
  .user_irq(user_irq)
);

//--- tb/srm_pin_model.sv
module srm_pin_model (
  input wire logic clk,
  input wire logic pin_oe,
  input wire logic ext_low,
  output logic pin_in,
  output int oe_len
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // The pin has a pull-up, so it reads high once nobody pulls it low.
  assign pin_in = !(pin_oe || ext_low);
  always @(posedge clk) begin
    n <= pin_oe ? n + 1 : 0;
    if (!pin_oe && n != 0) oe_len <= n;
  end
endmodule : srm_pin_model

//--- tb/test_srm_top.sv
module test_srm_top
  import srm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int D = 4;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ext = 1'b0, wdt_fault = 1'b0, backup_exit = 1'b0;
  logic core_rst_b = 1'b0, watchdog_reset_enable = 1'b1;
  logic watchdog_processor_only = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin_in, pin_out, pin_oe, er, user_irq, wdt_rst_b;
  logic proc_rst_b, coproc_rst_b, periph_rst_b, coproc_periph_rst_b;
  logic [5:0] lo = 6'h00;
  logic lo_clr = 1'b0;
  int fail_count = 0, checked = 0, oe_len;
  srm_top #(.DIV(D)) u_srm_top (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .core_rst_b(core_rst_b),
    .backup_exit(backup_exit),
    .wdt_fault(wdt_fault),
    .watchdog_reset_enable(watchdog_reset_enable),
    .watchdog_processor_only(watchdog_processor_only),
    .proc_rst_b(proc_rst_b),
    .coproc_rst_b(coproc_rst_b),
    .periph_rst_b(periph_rst_b),
    .coproc_periph_rst_b(coproc_periph_rst_b),
    .wdt_rst_b(wdt_rst_b),
    .user_irq(user_irq)
  );
  srm_pin_model u_srm_pin_model (.clk(clk), .pin_oe(pin_oe),
    .ext_low(ext), .pin_in(pin_in), .oe_len(oe_len));
  initial forever #25 clk = ~clk;
  // Each bit remembers that its output was seen active since the last clear.
  always @(posedge clk) begin
    if (lo_clr) begin
      lo <= 6'h00;
    end else begin
      lo <= lo | {~wdt_rst_b, pin_oe, ~proc_rst_b, ~periph_rst_b,
        ~(coproc_rst_b & coproc_periph_rst_b), user_irq};
    end
  end
  task automatic chk(input logic [31:0] s, e, input string n);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic st(input logic [2:0] c);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h700, 32'(c) << SR_CAUSE_LSB, "cause");
  endtask : st
  task automatic clr;
    lo_clr <= 1'b1;
    @(posedge clk);
    lo_clr <= 1'b0;
  endtask : clr
  // Eighty cycles outlast the longest pulse, so each case starts idle.
  task automatic fire(input logic po, en, input logic [5:0] e);
    watchdog_processor_only <= po;
    watchdog_reset_enable <= en;
    clr();
    wdt_fault <= 1'b1;
    @(posedge clk);
    wdt_fault <= 1'b0;
    repeat (80) @(posedge clk);
    chk(32'(lo), 32'(e), "watchdog resets");
  endtask : fire
  task automatic low(input logic [31:0] m, input int n, input logic [5:0] e);
    apb(1'b1, ADDR_MODE, m);
    clr();
    ext <= 1'b1;
    repeat (n * D) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    ext <= 1'b0;
    repeat (80) @(posedge clk);
    chk(32'(lo), 32'(e), "pin resets");
  endtask : low
  task automatic t_gen;
    repeat (80) @(posedge clk);
    chk(oe_len, 2 * D, "pin width");
    chk(32'(pin_out), 32'h0, "pin drive level");
    st(CAUSE_GENERAL);
    apb(1'b1, ADDR_CTRL, 32'hFFFFFFFF);
    chk(32'(er), 32'h0, "control write");
    apb(1'b0, ADDR_MODE, 32'h0);
    chk(rd, 32'h1, "mode reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped");
    $display("t_gen done");
  endtask : t_gen
  task automatic t_wdt;
    fire(1'b0, 1'b0, 6'h00);
    st(CAUSE_GENERAL);
    apb(1'b1, ADDR_MODE, 32'h101);
    fire(1'b0, 1'b1, 6'h3C);
    chk(oe_len, 4 * D, "pin width");
    st(CAUSE_WATCHDOG);
    fire(1'b1, 1'b1, 6'h28);
    $display("t_wdt done");
  endtask : t_wdt
  task automatic t_pin;
    low(32'h101, 2, 6'h00);
    low(32'h100, 6, 6'h00);
    chk(rd & 32'h10001, 32'h1, "status low");
    low(32'h110, 6, 6'h01);
    low(32'h101, 6, 6'h2E);
    st(CAUSE_USER);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h10001, 32'h10000, "status high");
    $display("t_pin done");
  endtask : t_pin
  task automatic t_bkp;
    clr();
    backup_exit <= 1'b1;
    core_rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    core_rst_b <= 1'b1;
    repeat (80) @(posedge clk);
    backup_exit <= 1'b0;
    chk(32'(lo), 32'h3E, "core resets");
    chk(oe_len, 4 * D, "pin width");
    st(CAUSE_BACKUP);
    $display("t_bkp done");
  endtask : t_bkp
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    core_rst_b <= 1'b1;
    t_gen();
    t_wdt();
    t_pin();
    t_bkp();
    results();
  end
endmodule : test_srm_top
